// *** hw/pcf_follower.sv ***
// Purpose: pulse command follower with following error tracking
// Assumes: pins asynchronous to hclk, torque_sat from logic on hclk
// Notes: command and feedback both in encoder counts; registered AHB-Lite slave
//   command pins pass a glitch filter, the motor encoder pins do not
//   read data comes one cycle after the address phase, no wait states
//   a mode or signal type change may leave one stray count behind
//
// Summary of operation
// - pulse/pulse: channel A pulse adds one, channel B pulse subtracts one.
// - pulse/direction: A pulses counted, up when B high, down when low.
// - quadrature: B leading A counts up, A leading B counts down.
// - quadrature: every edge of A and B gives one count, except a double change, which gives none.
// - differential path follows up to 1 MHz per channel.
// - single-ended path follows up to 500 kHz per channel.
// - signal type selects receiver path; differential after reset.
// - single-ended step input acts on falling edge; direction high is positive.
// - single-ended plus input falling is positive, minus input falling negative.
// - accumulator, command, encoder count and feedback zero at reset.
// - only the encoder count accepts a software preload.
// - position command is accumulator times revolutions over master pulses.
// - signed numerator; negative value reverses pulse driven motion.
// - following error is command minus feedback.
// - disabling the drive clears accumulated following error.
// - limit in revolutions, bounded, own enable, active in pulse mode only.
// - without limit, error saturates at 2863.3 revolutions, never wraps.
// - enabled limit compares error magnitude and raises a fault.
// - velocity mode ignores limit; error beyond torque saturation dropped.
// - encoder count tracks motor; direction bit picks counting sense.
`default_nettype none
module pcf_follower (
    input wire logic hclk,
    input wire logic hresetn,
    input wire pcf_pkg::pcf_ahb_req_t ahb_req,
    output pcf_pkg::pcf_ahb_rsp_t ahb_rsp,
    input wire logic diff_a,
    input wire logic diff_b,
    input wire logic step_plus_n,
    input wire logic step_minus_n,
    input wire logic enc_a,
    input wire logic enc_b,
    input wire logic torque_sat,
    output logic fe_fault,
    output logic [31:0] pos_command,
    output logic [31:0] follow_error
);
    pcf_pkg::pcf_state_t r;
    pcf_pkg::pcf_state_t n;

    // quadrature step from previous and current levels {a,b}
    // t is {a_old, b_old, a_new, b_new}; a double change gives no step
    // because the order of the two edges is lost then
    function automatic logic signed [1:0] quad_step(input logic [3:0] t);
        case (t)
            // b moved ahead of a: forward
            4'h1, 4'h7, 4'he, 4'h8: begin
                quad_step = 2'sh1;
            end
            // a moved ahead of b: backward
            4'h2, 4'hb, 4'hd, 4'h4: begin
                quad_step = -2'sh1;
            end
            // no change, or both changed together
            default: begin
                quad_step = 2'sh0;
            end
        endcase
    endfunction

    // magnitude of a signed count
    // the most negative value stays negative; saturation keeps it away
    function automatic logic [31:0] mag(input logic [31:0] v);
        mag = v[31] ? (~v + 32'h1) : v;
    endfunction

    // saturate to the error range, about 2863 revolutions each way
    // clamping avoids a sign flip when the error grows for a long time
    function automatic logic [31:0] sat(input logic signed [31:0] v);
        if (v > pcf_pkg::FE_SAT_CNT) begin
            sat = pcf_pkg::FE_SAT_CNT;
        end else if (v < -pcf_pkg::FE_SAT_CNT) begin
            sat = -pcf_pkg::FE_SAT_CNT;
        end else begin
            sat = v;
        end
    endfunction

    // decoded settings and pin decode
    pcf_pkg::pcf_mode_t mode;
    logic se_sel;
    logic [1:0] raw;
    logic [6:0] filt_len;
    logic rise_a;
    logic rise_b;

    // count steps and arithmetic
    logic signed [1:0] d_cmd;
    logic signed [1:0] d_enc;
    logic signed [47:0] prod;
    logic signed [47:0] quo;
    logic [31:0] fe_raw;
    logic [31:0] fe_err;

    // bus side
    logic addr_ph;
    logic [31:0] rd_mux;

    // limit violation seen this cycle; beats a same-cycle clear
    logic fault_set;

    // next state logic, all in one pass
    // s1..s3: pin synchroniser stages; flt, fcnt: command glitch filter
    // ctrl, rnum, rden, felim: software settings
    // acc, cmd, enc, base, fe, fault: counting and error tracking
    // wr_pend, wr_addr, rdata: bus pipeline between address and data phase
    always_comb begin
        n = r;
        mode = pcf_pkg::pcf_mode_t'(r.ctrl[pcf_pkg::CTRL_MODE_LSB +: 2]);
        se_sel = r.ctrl[pcf_pkg::CTRL_SE_BIT];
        raw = 2'h0;
        filt_len = pcf_pkg::FILT_DIFF;
        rise_a = 1'b0;
        rise_b = 1'b0;
        d_cmd = 2'sh0;
        d_enc = 2'sh0;
        prod = 48'sh0;
        quo = 48'sh0;
        fe_raw = 32'h0;
        fe_err = 32'h0;
        addr_ph = 1'b0;
        rd_mux = 32'h0;
        fault_set = 1'b0;

        // two-stage synchroniser
        // only s2 and s3 feed logic; s1 may still be settling
        // s3 exists for the unfiltered encoder edge compare
        n.s1 = {enc_b, enc_a, step_minus_n, step_plus_n, diff_b, diff_a};
        n.s2 = r.s1;
        n.s3 = r.s2;

        // receiver path selection
        // control reset value leaves the differential path selected
        // switching paths mid-run may leave one stray count behind
        if (se_sel) begin
            filt_len = pcf_pkg::FILT_SE;
            if (mode == pcf_pkg::PCF_MODE_QD) begin
                raw = {r.s2[3], r.s2[2]};
            end else if (mode == pcf_pkg::PCF_MODE_PD) begin
                // falling step counts, direction as is
                raw = {r.s2[3], ~r.s2[2]};
            end else begin
                // falling edges of plus and minus inputs
                raw = {~r.s2[3], ~r.s2[2]};
            end
        end else begin
            raw = {r.s2[1], r.s2[0]};
        end

        // glitch filter scaled to the receiver rate
        // a level must hold filt_len cycles, a quarter of the least legal
        // edge spacing, so noise is dropped yet the top rate still passes
        // trade-off: every count is delayed by filt_len cycles
        for (int i = 0; i < 2; i++) begin
            if (raw[i] == r.flt[i]) begin
                // level unchanged: restart
                n.fcnt[i] = 7'h0;
            end else if (r.fcnt[i] >= filt_len - 7'h1) begin
                // held long enough: accept
                n.flt[i] = raw[i];
                n.fcnt[i] = 7'h0;
            end else begin
                // still counting
                n.fcnt[i] = r.fcnt[i] + 7'h1;
            end
        end
        rise_a = n.flt[0] & ~r.flt[0];
        rise_b = n.flt[1] & ~r.flt[1];

        // command count decode per interpretation mode
        case (mode)
            pcf_pkg::PCF_MODE_PP: begin
                // a adds, b subtracts
                // both in one cycle cancel out: no count
                if (rise_a && !rise_b) begin
                    d_cmd = 2'sh1;
                end else if (rise_b && !rise_a) begin
                    d_cmd = -2'sh1;
                end
            end
            pcf_pkg::PCF_MODE_PD: begin
                if (rise_a && r.flt[1]) begin
                    d_cmd = 2'sh1;
                end else if (rise_a) begin
                    d_cmd = -2'sh1;
                end
            end
            pcf_pkg::PCF_MODE_QD: begin
                // every edge, b leading is positive
                // an illegal double change is dropped
                d_cmd = quad_step({r.flt[0], r.flt[1], n.flt[0], n.flt[1]});
            end
            default: begin
                d_cmd = 2'sh0;
            end
        endcase

        // accumulator totals all counts from zero
        n.acc = r.acc + {{30{d_cmd[1]}}, d_cmd};

        // encoder count with selectable sense
        // no filter here; the motor encoder is a trusted local source
        // a preload write below overrides this cycle's count
        d_enc = quad_step({r.s3[4], r.s3[5], r.s2[4], r.s2[5]});
        if (r.ctrl[pcf_pkg::CTRL_DIR_BIT]) begin
            d_enc = -d_enc;
        end
        n.enc = r.enc + {{30{d_enc[1]}}, d_enc};

        // signed ratio scaling, zero denominator holds
        // 48-bit product cannot overflow for a 32-bit count, 16-bit ratio
        // division truncates toward zero, so small ratios can hide counts
        // a zero denominator freezes the command at its last value
        prod = $signed(r.acc) * $signed(r.rnum);
        if (r.rden != 16'h0) begin
            quo = prod / $signed({32'h0, r.rden});
            n.cmd = quo[31:0];
        end

        // error is command minus feedback
        // base holds the error parked at disable or absorbed at saturation
        fe_raw = r.cmd - r.enc;
        fe_err = fe_raw - r.base;
        if (!r.ctrl[pcf_pkg::CTRL_EN_BIT]) begin
            // disabled drive re-bases the error to zero
            n.base = fe_raw;
            n.fe = 32'h0;
        end else if (!r.ctrl[pcf_pkg::CTRL_PULSE_BIT] && torque_sat
                     && mag(sat(fe_err)) > mag(r.fe)) begin
            // growth past torque saturation is dropped
            // the error keeps its value; the extra goes into base
            n.base = fe_raw - r.fe;
        end else begin
            n.fe = sat(fe_err);
        end

        // limit only in pulse mode when enabled
        // strict compare: an error equal to the limit is still legal
        if (r.ctrl[pcf_pkg::CTRL_PULSE_BIT] && r.ctrl[pcf_pkg::CTRL_LIMEN_BIT]
            && mag(r.fe) > r.felim) begin
            fault_set = 1'b1;
        end
        // fault is sticky until software clears it
        if (fault_set) begin
            n.fault = 1'b1;
        end

        // register read mux, sampled in the address phase
        // upper address bits are ignored, so the map aliases
        case (ahb_req.haddr[7:0])
            pcf_pkg::OFS_CTRL: begin
                rd_mux = {25'h0, r.ctrl};
            end
            // numerator reads back sign-extended
            pcf_pkg::OFS_RNUM: begin
                rd_mux = {{16{r.rnum[15]}}, r.rnum};
            end
            pcf_pkg::OFS_RDEN: begin
                rd_mux = {16'h0, r.rden};
            end
            pcf_pkg::OFS_FELIM: begin
                rd_mux = r.felim;
            end
            pcf_pkg::OFS_ACC: begin
                rd_mux = r.acc;
            end
            pcf_pkg::OFS_CMD: begin
                rd_mux = r.cmd;
            end
            pcf_pkg::OFS_ENC: begin
                rd_mux = r.enc;
            end
            pcf_pkg::OFS_FERR: begin
                rd_mux = r.fe;
            end
            pcf_pkg::OFS_STAT: begin
                rd_mux = {31'h0, r.fault};
            end
            // unmapped offsets read as zero
            default: begin
                rd_mux = 32'h0;
            end
        endcase

        // address phase capture
        // read data is latched now so it stands through the data phase
        // a write waits one cycle for hwdata, as the bus demands
        addr_ph = ahb_req.hsel & ahb_req.htrans[1] & ahb_req.hready;
        n.wr_pend = addr_ph & ahb_req.hwrite;
        n.wr_addr = ahb_req.haddr[7:0];
        if (addr_ph && !ahb_req.hwrite) begin
            n.rdata = rd_mux;
        end

        // data phase write; accumulator, command and error ignore writes
        if (r.wr_pend) begin
            case (r.wr_addr)
                pcf_pkg::OFS_CTRL: begin
                    n.ctrl = ahb_req.hwdata[6:0];
                end
                pcf_pkg::OFS_RNUM: begin
                    n.rnum = ahb_req.hwdata[15:0];
                end
                // zero here freezes the command, no divide fault
                pcf_pkg::OFS_RDEN: begin
                    n.rden = ahb_req.hwdata[15:0];
                end
                pcf_pkg::OFS_FELIM: begin
                    if (ahb_req.hwdata < pcf_pkg::FE_LIM_MIN) begin
                        n.felim = pcf_pkg::FE_LIM_MIN;
                    end else if (ahb_req.hwdata > pcf_pkg::FE_LIM_MAX) begin
                        n.felim = pcf_pkg::FE_LIM_MAX;
                    end else begin
                        n.felim = ahb_req.hwdata;
                    end
                end
                // encoder count alone takes a preload
                pcf_pkg::OFS_ENC: begin
                    n.enc = ahb_req.hwdata;
                end
                pcf_pkg::OFS_STAT: begin
                    // write one clears; a violation in the same cycle still wins
                    if (ahb_req.hwdata[pcf_pkg::STAT_FAULT_BIT] && !fault_set) begin
                        n.fault = 1'b0;
                    end
                end
                // read-only and unmapped offsets drop the write
                default: begin
                end
            endcase
        end
    end

    // single state register
    // reset loads constants only; settings start at their defaults
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            r <= '0;
            r.ctrl <= pcf_pkg::CTRL_RST;
            r.rnum <= pcf_pkg::RNUM_RST;
            r.rden <= pcf_pkg::RDEN_RST;
            r.felim <= pcf_pkg::FE_LIM_RST;
        end else begin
            r <= n;
        end
    end

    // outputs straight from state flops; zero wait, always okay
    // one assignment of the whole response keeps it a single driver
    assign ahb_rsp = '{hrdata: r.rdata, hreadyout: 1'b1, hresp: 1'b0};
    assign fe_fault = r.fault;
    assign pos_command = r.cmd;
    assign follow_error = r.fe;
endmodule
`default_nettype wire

// *** hw/pcf_pkg.sv ***
// Purpose: shared constants and carriers for the pulse command follower
// Assumes: 250 MHz hclk, AHB-Lite register access, word-aligned registers
// Notes: positions and errors are kept in motor encoder counts
`default_nettype none
package pcf_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_RNUM = 8'h04;
    localparam logic [7:0] OFS_RDEN = 8'h08;
    localparam logic [7:0] OFS_FELIM = 8'h0c;
    localparam logic [7:0] OFS_ACC = 8'h10;
    localparam logic [7:0] OFS_CMD = 8'h14;
    localparam logic [7:0] OFS_ENC = 8'h18;
    localparam logic [7:0] OFS_FERR = 8'h1c;
    localparam logic [7:0] OFS_STAT = 8'h20;
    // control field positions
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_SE_BIT = 2;
    localparam int CTRL_EN_BIT = 3;
    localparam int CTRL_PULSE_BIT = 4;
    localparam int CTRL_LIMEN_BIT = 5;
    localparam int CTRL_DIR_BIT = 6;
    localparam int STAT_FAULT_BIT = 0;
    // reset values: pulse mode, pulse/pulse, differential, disabled
    localparam logic [6:0] CTRL_RST = 7'h10;
    localparam logic [15:0] RNUM_RST = 16'h0001;
    localparam logic [15:0] RDEN_RST = 16'h0001;
    // interpretation modes
    typedef enum logic [1:0] {
        PCF_MODE_PP = 2'h0,
        PCF_MODE_PD = 2'h1,
        PCF_MODE_QD = 2'h2
    } pcf_mode_t;
    // input timing
    localparam int CLK_PERIOD_NS = 4;
    localparam int FMAX_DIFF_KHZ = 1000;
    localparam int FMAX_SE_KHZ = 500;
    localparam int EDGE_FRAC_PCT = 20;
    localparam int EDGE_DIFF_NS = EDGE_FRAC_PCT * 10000 / FMAX_DIFF_KHZ;
    localparam int EDGE_SE_NS = EDGE_FRAC_PCT * 10000 / FMAX_SE_KHZ;
    localparam int EDGE_DIFF_CYC = (EDGE_DIFF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int EDGE_SE_CYC = (EDGE_SE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // glitch filter lengths, a quarter of the least edge spacing
    localparam logic [6:0] FILT_DIFF = 7'(EDGE_DIFF_CYC / 4);
    localparam logic [6:0] FILT_SE = 7'(EDGE_SE_CYC / 4);
    // following error scaling
    localparam int ENC_CPR = 8192;
    localparam int FE_SAT_TENTHS = 28633;
    localparam int FE_LIM_MIN_MILLI = 1;
    localparam int FE_LIM_MAX_MILLI = 10000;
    localparam logic signed [31:0] FE_SAT_CNT = 32'(FE_SAT_TENTHS * ENC_CPR / 10);
    localparam logic [31:0] FE_LIM_MIN = 32'((FE_LIM_MIN_MILLI * ENC_CPR + 999) / 1000);
    localparam logic [31:0] FE_LIM_MAX = 32'(FE_LIM_MAX_MILLI * ENC_CPR / 1000);
    localparam logic [31:0] FE_LIM_RST = 32'(ENC_CPR);
    // bus carriers
    typedef struct packed {
        logic hsel;
        logic [31:0] haddr;
        logic [1:0] htrans;
        logic hwrite;
        logic [2:0] hsize;
        logic [31:0] hwdata;
        logic hready;
    } pcf_ahb_req_t;
    typedef struct packed {
        logic [31:0] hrdata;
        logic hreadyout;
        logic hresp;
    } pcf_ahb_rsp_t;
    // whole state of the follower
    typedef struct packed {
        logic [5:0] s1;
        logic [5:0] s2;
        logic [5:0] s3;
        logic [1:0] flt;
        logic [1:0][6:0] fcnt;
        logic [6:0] ctrl;
        logic [15:0] rnum;
        logic [15:0] rden;
        logic [31:0] felim;
        logic [31:0] acc;
        logic [31:0] cmd;
        logic [31:0] enc;
        logic [31:0] base;
        logic [31:0] fe;
        logic fault;
        logic wr_pend;
        logic [7:0] wr_addr;
        logic [31:0] rdata;
    } pcf_state_t;
endpackage
`default_nettype wire

// *** dv/pcf_src.sv ***
// Purpose: upstream pulse source and motor encoder model
// Assumes: driven from hclk edges by non-blocking assignment
// Notes: p[1:0] differential a/b, p[3:2] single-ended pins, p[5:4] encoder
`default_nettype none
module pcf_src (
    input wire logic clk,
    output logic [5:0] p
);
    timeunit 1ns;
    timeprecision 1ps;
    // single-ended pins rest high on their pull-ups
    initial p = 6'h0c;
    task automatic tg(input int c, input int g);
        @(posedge clk);
        p[c] <= ~p[c];
        repeat (g - 1) @(posedge clk);
    endtask
    // whole pulses: two edges each
    task automatic pulses(input int c, input int n, input int g);
        repeat (2 * n) tg(c, g);
    endtask
    // quadrature steps, b leads a when up is set
    task automatic qn(input int c, input bit up, input int n, input int g);
        repeat (n) tg(((p[c] == p[c + 1]) == up) ? c + 1 : c, g);
    endtask
endmodule
`default_nettype wire

// *** dv/pcf_follower_chk.sv ***
// Purpose: port level checks of the pulse command follower
// Assumes: one hclk domain, asynchronous active low reset
// Notes: quiet counters stand in for the unseen pipeline depth
`default_nettype none
module pcf_follower_chk (
    input wire logic hclk,
    input wire logic hresetn,
    input wire pcf_pkg::pcf_ahb_req_t ahb_req,
    input wire pcf_pkg::pcf_ahb_rsp_t ahb_rsp,
    input wire logic diff_a,
    input wire logic diff_b,
    input wire logic step_plus_n,
    input wire logic step_minus_n,
    input wire logic enc_a,
    input wire logic enc_b,
    input wire logic torque_sat,
    input wire logic fe_fault,
    input wire logic [31:0] pos_command,
    input wire logic [31:0] follow_error
);
    logic [5:0] qa;
    logic [5:0] qc;
    logic [1:0] wst;
    logic xfer;
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    // a taken transfer may alter ratio, preload or mode
    assign xfer = ahb_req.hsel && ahb_req.htrans[1] && ahb_req.hready;
    // cycles since the last possible cause of change, saturating
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            qa <= 6'h00;
            qc <= 6'h00;
            wst <= 2'h0;
        end else begin
            qc <= (xfer || $changed({diff_a, diff_b, step_plus_n, step_minus_n})) ? 6'h00
                : qc + 6'(qc != 6'h3f);
            qa <= (xfer || $changed({diff_a, diff_b, step_plus_n, step_minus_n, enc_a, enc_b,
                torque_sat})) ? 6'h00 : qa + 6'(qa != 6'h3f);
            wst <= {wst[0], xfer && ahb_req.hwrite && ahb_req.haddr[7:0] == pcf_pkg::OFS_STAT};
        end
    end
    a_reset_zero: assert property ($rose(hresetn) |-> pos_command == 32'h0
        && follow_error == 32'h0 && !fe_fault)
        else $error("outputs not zero after reset");
    a_error_saturates: assert property ($signed(follow_error) <= pcf_pkg::FE_SAT_CNT
        && $signed(follow_error) >= -pcf_pkg::FE_SAT_CNT)
        else $error("following error beyond saturation");
    a_fault_cause: assert property ($rose(fe_fault) |->
        ($signed($past(follow_error)) >= 9 || $signed($past(follow_error)) <= -9))
        else $error("fault raised on small error");
    a_fault_sticky: assert property ($fell(fe_fault) |-> $past(|wst))
        else $error("fault dropped without a clear");
    a_cmd_quiet: assert property (qc >= 6'h30 |-> $stable(pos_command))
        else $error("command moved with no cause");
    a_err_quiet: assert property (qa >= 6'h30 |-> $stable(follow_error) && $stable(fe_fault))
        else $error("error moved with no cause");
    a_cmd_sync: assert property (qc >= 6'h30 && $changed({diff_a, diff_b, step_plus_n,
        step_minus_n}) |=> $stable(pos_command) [*3])
        else $error("command reacted too early");
    a_enc_sync: assert property (qa >= 6'h30 && $changed({enc_a, enc_b})
        |=> $stable(follow_error) [*2])
        else $error("error reacted too early");
endmodule
bind pcf_follower pcf_follower_chk u_chk (.hclk(hclk), .hresetn(hresetn), .ahb_req(ahb_req),
    .ahb_rsp(ahb_rsp), .diff_a(diff_a), .diff_b(diff_b), .step_plus_n(step_plus_n),
    .step_minus_n(step_minus_n), .enc_a(enc_a), .enc_b(enc_b), .torque_sat(torque_sat),
    .fe_fault(fe_fault), .pos_command(pos_command), .follow_error(follow_error));
`default_nettype wire

// *** dv/tb.sv ***
// Purpose: directed bench for the pulse command follower
// Assumes: 250 MHz hclk, zero wait AHB-Lite slave
// Notes: counts are measured from a fresh read after each mode change
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic torque_sat = 1'b0;
    logic [5:0] p;
    logic fe_fault;
    logic [31:0] pos_command;
    logic [31:0] follow_error;
    logic [31:0] base = 32'h0;
    logic [31:0] r;
    logic [31:0] rv [10];
    int n_mismatch = 0;
    int num_checks = 0;
    pcf_pkg::pcf_ahb_req_t q = '0;
    pcf_pkg::pcf_ahb_req_t req;
    pcf_pkg::pcf_ahb_rsp_t rsp;
    // 4 ns period
    always #2 hclk = ~hclk;
    // the one slave drives the bus ready
    always_comb begin
        req = q;
        req.hready = rsp.hreadyout;
    end
    pcf_src src (.clk(hclk), .p(p));
    pcf_follower dut (.hclk(hclk), .hresetn(hresetn), .ahb_req(req), .ahb_rsp(rsp),
        .diff_a(p[0]), .diff_b(p[1]), .step_plus_n(p[2]), .step_minus_n(p[3]),
        .enc_a(p[4]), .enc_b(p[5]), .torque_sat(torque_sat), .fe_fault(fe_fault),
        .pos_command(pos_command), .follow_error(follow_error));
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // address phase held until ready, then data phase until ready
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] o);
        q.hsel <= 1'b1;
        q.haddr <= {24'h0, a};
        q.htrans <= 2'h2;
        q.hwrite <= w;
        q.hsize <= 3'h2;
        do @(posedge hclk); while (rsp.hreadyout !== 1'b1);
        q.htrans <= 2'h0;
        q.hwdata <= d;
        do @(posedge hclk); while (rsp.hreadyout !== 1'b1);
        o = rsp.hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d, r);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0, r);
        chk($sformatf("reg %h", a), r, e);
    endtask
    // a mode change may add one stray count, so rebase
    task automatic mode(input logic [31:0] c);
        wr(pcf_pkg::OFS_CTRL, c);
        repeat (60) @(posedge hclk);
        bus(1'b0, pcf_pkg::OFS_ACC, 32'h0, base);
    endtask
    task automatic acc_chk(input int d);
        repeat (60) @(posedge hclk);
        base = base + 32'(d);
        rd(pcf_pkg::OFS_ACC, base);
        chk("pos_command", pos_command, base);
    endtask
    task automatic summarize();
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // hang guard, well beyond the directed run
    initial begin
        repeat (100000) @(posedge hclk);
        n_mismatch++;
        summarize();
    end
    initial begin
        rv = '{32'(pcf_pkg::CTRL_RST), 32'(pcf_pkg::RNUM_RST), 32'(pcf_pkg::RDEN_RST),
            pcf_pkg::FE_LIM_RST, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        // every register at reset, last one unmapped
        for (int i = 0; i < 10; i++) begin
            rd(8'(i * 4), rv[i]);
        end
        src.pulses(0, 3, 50);
        src.pulses(1, 1, 50);
        acc_chk(2);
        mode(32'h11);
        src.tg(1, 50);
        src.pulses(0, 2, 50);
        src.tg(1, 50);
        src.pulses(0, 1, 50);
        acc_chk(1);
        mode(32'h12);
        src.qn(0, 1'b1, 5, 50);
        src.qn(0, 1'b0, 2, 50);
        acc_chk(3);
        mode(32'h15);
        src.pulses(2, 2, 100);
        src.tg(3, 100);
        src.pulses(2, 1, 100);
        src.tg(3, 100);
        acc_chk(1);
        mode(32'h14);
        src.pulses(2, 2, 100);
        src.pulses(3, 1, 100);
        acc_chk(1);
        mode(32'h16);
        src.qn(2, 1'b1, 4, 100);
        acc_chk(4);
        mode(32'h10);
        wr(pcf_pkg::OFS_RNUM, 32'h0000fffe);
        rd(pcf_pkg::OFS_RNUM, 32'hfffffffe);
        rd(pcf_pkg::OFS_CMD, 32'(-2 * $signed(base)));
        wr(pcf_pkg::OFS_RNUM, 32'h3);
        wr(pcf_pkg::OFS_RDEN, 32'h2);
        repeat (4) @(posedge hclk);
        rd(pcf_pkg::OFS_CMD, 32'($signed(base) * 3 / 2));
        wr(pcf_pkg::OFS_RNUM, 32'h1);
        wr(pcf_pkg::OFS_RDEN, 32'h1);
        wr(pcf_pkg::OFS_ENC, 32'd100);
        wr(pcf_pkg::OFS_ACC, 32'h5);
        wr(pcf_pkg::OFS_CMD, 32'h5);
        wr(pcf_pkg::OFS_FERR, 32'h5);
        wr(8'h24, 32'h5);
        rd(pcf_pkg::OFS_ENC, 32'd100);
        rd(pcf_pkg::OFS_ACC, base);
        rd(pcf_pkg::OFS_CMD, base);
        rd(pcf_pkg::OFS_FERR, 32'h0);
        rd(8'h24, 32'h0);
        chk("hresp", 32'(rsp.hresp), 32'h0);
        mode(32'h18);
        src.pulses(0, 2, 50);
        repeat (60) @(posedge hclk);
        rd(pcf_pkg::OFS_FERR, 32'h2);
        src.qn(4, 1'b1, 3, 10);
        repeat (10) @(posedge hclk);
        rd(pcf_pkg::OFS_ENC, 32'd103);
        chk("follow_error", follow_error, 32'hffffffff);
        wr(pcf_pkg::OFS_CTRL, 32'h10);
        repeat (4) @(posedge hclk);
        rd(pcf_pkg::OFS_FERR, 32'h0);
        wr(pcf_pkg::OFS_FELIM, 32'h0);
        rd(pcf_pkg::OFS_FELIM, pcf_pkg::FE_LIM_MIN);
        wr(pcf_pkg::OFS_FELIM, 32'h00030000);
        rd(pcf_pkg::OFS_FELIM, pcf_pkg::FE_LIM_MAX);
        wr(pcf_pkg::OFS_FELIM, pcf_pkg::FE_LIM_MIN);
        mode(32'h38);
        src.qn(4, 1'b0, 9, 10);
        repeat (10) @(posedge hclk);
        rd(pcf_pkg::OFS_STAT, 32'h0);
        src.qn(4, 1'b0, 1, 10);
        repeat (10) @(posedge hclk);
        rd(pcf_pkg::OFS_STAT, 32'h1);
        wr(pcf_pkg::OFS_STAT, 32'h1);
        rd(pcf_pkg::OFS_STAT, 32'h1);
        src.qn(4, 1'b1, 10, 10);
        repeat (10) @(posedge hclk);
        wr(pcf_pkg::OFS_STAT, 32'h1);
        repeat (2) @(posedge hclk);
        chk("fe_fault", 32'(fe_fault), 32'h0);
        mode(32'h28);
        src.qn(4, 1'b0, 10, 10);
        repeat (10) @(posedge hclk);
        rd(pcf_pkg::OFS_STAT, 32'h0);
        torque_sat <= 1'b1;
        src.qn(4, 1'b0, 5, 10);
        repeat (10) @(posedge hclk);
        rd(pcf_pkg::OFS_FERR, 32'd10);
        torque_sat <= 1'b0;
        mode(32'h50);
        wr(pcf_pkg::OFS_ENC, 32'h0);
        src.qn(4, 1'b1, 2, 10);
        repeat (10) @(posedge hclk);
        rd(pcf_pkg::OFS_ENC, 32'hfffffffe);
        summarize();
    end
endmodule
`default_nettype wire
